// file: hdl/pdw_core.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - strobe line: latency flag, then byte mask
// - no extra latency: strobe low during command
// - extra latency: strobe high, then low, release
// - masked bytes stay unchanged in array
// - zero-latency write has no strobe turnaround
// - strobe driven from select, before any byte
// - zero-latency write ignores strobe latency level
// - zero-latency data: strobe held low, never released
// - zero-latency write stores every byte
// - strobe high masks byte, low writes it
module pdw_core
    import pdw_pkg::*;
#(
    parameter int unsigned DEPTH  = DEF_DEPTH,
    parameter int unsigned ADDR_W = $clog2(DEPTH)
)(
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic [LAT_W-1:0]  cfg_latency,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output var  logic [15:0]       peek_data,
    output var  logic              refresh_pending,
    input  wire logic              link_clk,
    input  wire logic              cs_n,
    input  wire logic [7:0]        dq_in,
    input  wire logic              smask_in,
    output var  logic              smask_out,
    output var  logic              smask_oe
);

    localparam logic [1:0] CA_LAST = 2'(CA_CYCLES - 1);

    logic [15:0]          mem [DEPTH];
    pdw_state_t           st;
    logic [1:0]           cnt;
    logic [LAT_W:0]       lat_cnt;
    logic                 first_lat;
    logic                 zero;
    logic [ADDR_W-1:0]    addr;
    logic [CA_SR_W-1:0]   ca_sr;
    logic [7:0]           byte_a;
    logic                 mask_a;
    logic                 started;
    logic                 extra_q;
    logic                 ref_s;
    logic [LAT_W-1:0]     cfg_s;
    logic                 ref_tgl;
    logic                 link_clr;
    pdw_beat_t            beat;
    pdw_ca_t              ca_now;
    logic                 ca_done;
    logic [LAT_W:0]       next_lat;
    logic [REFRESH_W-1:0] ref_timer;
    logic                 tgl_s;
    logic                 tgl_q;
    logic                 cs_idle;

    // Link side: word of the current clock, complete at its falling edge
    assign beat.data = {byte_a, dq_in};
    assign beat.mask = {mask_a, smask_in};
    assign ca_now    = pdw_ca_t'({ca_sr, beat.data});
    assign ca_done   = (st == ST_CA) && (cnt == CA_LAST);

    always_comb
    begin
        if (ca_now.reg_space)
            next_lat = '0;
        else if (extra_q)
            next_lat = {cfg_s, 1'b0};
        else
            next_lat = {1'b0, cfg_s};
    end

    pdw_sync #(.W(1), .ASYNC(1'b1)) u_ref_sync (
        .clk (link_clk),
        .clr (link_clr),
        .d   (refresh_pending),
        .q   (ref_s)
    );

    // Latency is quasi-static: change it only while the bus is idle
    pdw_sync #(.W(LAT_W), .ASYNC(1'b1)) u_lat_sync (
        .clk (link_clk),
        .clr (link_clr),
        .d   (cfg_latency),
        .q   (cfg_s)
    );

    always_ff @(posedge link_clk)
    begin
        byte_a <= dq_in;
        mask_a <= smask_in;
    end

    // Extra latency is frozen at the first clock so the flag stays flat
    always_ff @(posedge link_clk or posedge cs_n)
    begin
        if (cs_n)
        begin
            started <= 1'b0;
            extra_q <= 1'b0;
        end
        else if (!started)
        begin
            started <= 1'b1;
            extra_q <= ref_s;
        end
    end

    always_ff @(negedge link_clk)
    begin
        ca_sr <= {ca_sr[CA_SR_W-17:0], beat.data};
    end

    // Select high ends the frame without needing any clock edge
    always_ff @(negedge link_clk or posedge cs_n)
    begin
        if (cs_n)
        begin
            st        <= ST_CA;
            cnt       <= '0;
            lat_cnt   <= '0;
            first_lat <= 1'b0;
            zero      <= 1'b0;
            addr      <= '0;
        end
        else
        begin
            case (st)
                ST_CA:
                begin
                    cnt <= cnt + 2'h1;
                    if (ca_done)
                    begin
                        addr    <= ADDR_W'({ca_now.row, ca_now.col});
                        zero    <= ca_now.reg_space;
                        lat_cnt <= next_lat;
                        if (ca_now.read)
                            st <= ST_SKIP;
                        else if (next_lat == '0)
                            st <= ST_DATA;
                        else
                        begin
                            st        <= ST_LAT;
                            first_lat <= 1'b1;
                        end
                    end
                end
                ST_LAT:
                begin
                    first_lat <= 1'b0;
                    lat_cnt   <= lat_cnt - 1'b1;
                    if (lat_cnt == (LAT_W+1)'(1))
                        st <= ST_DATA;
                end
                ST_DATA:
                    addr <= addr + 1'b1;
                ST_SKIP:
                    st <= ST_SKIP;
                default:
                    st <= ST_CA;
            endcase
        end
    end

    // Byte lanes written on their own; bursts run linear, wrap is not kept
    generate
        for (genvar i = 0; i < BYTE_LANES; i++)
        begin : g_lane
            always_ff @(negedge link_clk)
            begin
                if (!cs_n && st == ST_DATA && (zero || !beat.mask[i]))
                    mem[addr][i*8 +: 8] <= beat.data[i*8 +: 8];
            end
        end
    endgenerate

    always_ff @(negedge link_clk or posedge link_clr)
    begin
        if (link_clr)
            ref_tgl <= 1'b0;
        else if (!cs_n && ca_done && !ca_now.read && !ca_now.reg_space
                 && extra_q)
            ref_tgl <= ~ref_tgl;
    end

    // Strobe line is driven as soon as select falls
    always_comb
    begin
        smask_oe  = !cs_n && ((st == ST_CA)
                    || (st == ST_LAT && first_lat)
                    || (st == ST_DATA && zero));
        smask_out = !cs_n && (st == ST_CA)
                    && (started ? extra_q : ref_s);
    end

    // System side: refresh pacing and the link's acknowledge
    always_ff @(posedge clk_sys)
    begin
        link_clr <= !resetn;
    end

    pdw_sync #(.W(1), .ASYNC(1'b0)) u_ack_sync (
        .clk (clk_sys),
        .clr (!resetn),
        .d   (ref_tgl),
        .q   (tgl_s)
    );

    pdw_sync #(.W(1), .ASYNC(1'b0)) u_cs_sync (
        .clk (clk_sys),
        .clr (!resetn),
        .d   (cs_n),
        .q   (cs_idle)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ref_timer       <= '0;
            tgl_q           <= 1'b0;
            refresh_pending <= RST_PENDING;
        end
        else
        begin
            tgl_q <= tgl_s;
            if (ref_timer == REFRESH_W'(REFRESH_CYC - 1))
                ref_timer <= '0;
            else
                ref_timer <= ref_timer + 1'b1;
            // A new tick wins over an acknowledge in the same cycle
            if (ref_timer == REFRESH_W'(REFRESH_CYC - 1))
                refresh_pending <= 1'b1;
            else if (tgl_s != tgl_q)
                refresh_pending <= 1'b0;
        end
    end

    // Array is only sampled while no frame runs, so it is static then
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            peek_data <= RST_PEEK;
        else if (cs_idle)
            peek_data <= mem[peek_addr];
    end

    // Checks on the link domain
    logic [7:0] old_hi;
    logic [7:0] old_lo;
    assign old_hi = mem[addr][15:8];
    assign old_lo = mem[addr][7:0];

    default clocking cb @(negedge link_clk);
    endclocking
    default disable iff (cs_n);

    sequence s_ca_zero;
        ca_done && !ca_now.read && ca_now.reg_space;
    endsequence

    sequence s_ca_extra;
        ca_done && !ca_now.read && !ca_now.reg_space && extra_q;
    endsequence

    AST_CA_DRIVEN: assert property (st == ST_CA |-> smask_oe)
        else $error("strobe not driven in command phase");
    AST_CA_LOW: assert property (
        st == ST_CA && started && !extra_q |-> !smask_out)
        else $error("strobe high without extra latency");
    AST_CA_HIGH: assert property (
        st == ST_CA && started && extra_q |-> smask_out)
        else $error("strobe low with extra latency");
    AST_TURN: assert property (
        s_ca_extra |=> (smask_oe && !smask_out) ##1 !smask_oe)
        else $error("strobe not returned low then released");
    AST_ZERO_LAT: assert property (
        s_ca_zero |=> st == ST_DATA && smask_oe && !smask_out)
        else $error("zero-latency write not straight to data");
    AST_DOUBLE: assert property (
        s_ca_extra |=> lat_cnt == {$past(cfg_s), 1'b0})
        else $error("extra latency not twice the count");
    AST_MASK_KEEP: assert property (
        st == ST_DATA && !zero && beat.mask[1]
        |=> mem[$past(addr)][15:8] == $past(old_hi))
        else $error("masked upper byte changed");
    AST_UNMASK_WRITE: assert property (
        st == ST_DATA && !zero && !beat.mask[0]
        |=> mem[$past(addr)][7:0] == $past(beat.data[7:0]))
        else $error("unmasked lower byte not written");
    AST_ZERO_FULL: assert property (
        st == ST_DATA && zero
        |=> mem[$past(addr)] == $past(beat.data))
        else $error("zero-latency word not fully written");

endmodule

`default_nettype wire

// file: hdl/pdw_pkg.sv
package pdw_pkg;

    // Command-address is six bytes, two per clock
    localparam int unsigned CA_CYCLES      = 3;
    localparam int unsigned CA_SR_W        = 32;
    localparam int unsigned LAT_W          = 4;
    localparam int unsigned DEF_DEPTH      = 64;
    localparam int unsigned BYTE_LANES     = 2;

    // Clock of the system side, and the refresh pacing derived from the
    // longest time the host may keep the part selected
    localparam int unsigned SYS_PERIOD_NS  = 100;
    localparam int unsigned SEL_MAX_LOW_NS = 4000;
    localparam int unsigned REFRESH_CYC    = SEL_MAX_LOW_NS / SYS_PERIOD_NS;
    localparam int unsigned REFRESH_W      = $clog2(REFRESH_CYC);

    // Reset values
    localparam logic        RST_PENDING    = 1'b0;
    localparam logic [15:0] RST_PEEK       = 16'h0000;

    typedef struct packed {
        logic        read;
        logic        reg_space;
        logic        linear;
        logic [28:0] row;
        logic [12:0] rsvd;
        logic [2:0]  col;
    } pdw_ca_t;

    // One DDR word: first byte in the upper lane
    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  mask;
    } pdw_beat_t;

    typedef enum logic [3:0] {
        ST_CA   = 4'h1,
        ST_LAT  = 4'h2,
        ST_DATA = 4'h4,
        ST_SKIP = 4'h8
    } pdw_state_t;

endpackage

// file: hdl/pdw_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage level synchroniser; the output moves only when stages two
// and three agree, so a single metastable sample cannot leak through.
module pdw_sync
    import pdw_pkg::*;
#(
    parameter int unsigned W     = 1,
    parameter bit          ASYNC = 1'b0
)(
    input  wire logic         clk,
    input  wire logic         clr,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    generate
        if (ASYNC)
        begin : g_async
            always_ff @(posedge clk or posedge clr)
            begin
                if (clr)
                begin
                    s1 <= '0;
                    s2 <= '0;
                    s3 <= '0;
                    q  <= '0;
                end
                else
                begin
                    s1 <= d;
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        q <= s3;
                end
            end
        end
        else
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (clr)
                begin
                    s1 <= '0;
                    s2 <= '0;
                    s3 <= '0;
                    q  <= '0;
                end
                else
                begin
                    s1 <= d;
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        q <= s3;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: bench/pdw_host.sv
`timescale 1ns/100ps
`default_nettype none

// Host side of the link; the clock stands low between frames
module pdw_host
    import pdw_pkg::*;
(
    output var  logic       link_clk,
    output var  logic       cs_n,
    output var  logic [7:0] dq_in,
    output var  logic       smask_wire,
    input  wire logic       smask_out,
    input  wire logic       smask_oe
);
    logic hoe;
    logic hval;
    logic last;
    logic fault;
    logic ca_lvl;

    // Undriven line shows the inverse of its last driven level
    assign smask_wire = smask_oe ? smask_out : (hoe ? hval : ~last);

    always @(link_clk)
        if (smask_oe || hoe)
            last <= smask_wire;

    initial
    begin
        link_clk = 1'b0;
        cs_n     = 1'b1;
        dq_in    = 8'h00;
        hoe      = 1'b0;
        hval     = 1'b0;
        last     = 1'b0;
        fault    = 1'b0;
        ca_lvl   = 1'b0;
    end

    task automatic half(input logic [7:0] b, input logic m, input logic d);
        dq_in = b;
        hval  = m;
        hoe   = d;
        #31.2;
        link_clk = ~link_clk;
        #31.3;
    endtask

    task automatic frame(input logic rd, input logic rs, input logic [5:0] a,
                         input int lat, input int nw,
                         input logic [1:0][15:0] d,
                         input logic [1:0][1:0] m);
        pdw_ca_t     ca;
        logic [47:0] cb;
        int          l;
        ca = '0;
        ca.read = rd;
        ca.reg_space = rs;
        ca.linear = 1'b1;
        ca.row = 29'(a[5:3]);
        ca.col = a[2:0];
        cb = ca;
        cs_n = 1'b0;
        #10;
        ca_lvl = smask_wire;
        if (smask_oe !== 1'b1) fault = 1'b1;
        // Checked ahead of each edge: the last falling edge ends the phase
        for (int i = 0; i < 6; i++)
        begin
            if (smask_oe !== 1'b1 || smask_wire !== ca_lvl) fault = 1'b1;
            half(cb[47 - 8 * i -: 8], 1'b0, 1'b0);
        end
        // Latency count matched to device and clock; doubled on request
        l = rs ? 0 : (ca_lvl ? 2 * lat : lat);
        repeat (2 * l) half(8'h00, 1'b0, 1'b0);
        for (int w = 0; w < nw; w++)
            for (int h = 1; h >= 0; h--)
            begin
                half(d[w][8 * h +: 8], m[w][h], !rs);
                if (smask_oe && hoe) fault = 1'b1;
                if (rs && smask_oe && smask_out) fault = 1'b1;
            end
        hoe  = 1'b0;
        cs_n = 1'b1;
        // Covers deselect and recovery minimums; frames stay short
        #200;
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    import pdw_pkg::*;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  cfg = 4'h2;
    logic [5:0]  pa = 6'h00;
    logic [15:0] peek_data;
    logic        pend;
    logic        link_clk;
    logic        cs_n;
    logic [7:0]  dq;
    logic        sm_out;
    logic        sm_oe;
    logic        sm_w;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    always #50 clk_sys = ~clk_sys;

    pdw_core pdw_core_inst (
        .clk_sys         (clk_sys),
        .resetn          (resetn),
        .cfg_latency     (cfg),
        .peek_addr       (pa),
        .peek_data       (peek_data),
        .refresh_pending (pend),
        .link_clk        (link_clk),
        .cs_n            (cs_n),
        .dq_in           (dq),
        .smask_in        (sm_w),
        .smask_out       (sm_out),
        .smask_oe        (sm_oe)
    );

    pdw_host pdw_host_inst (
        .link_clk   (link_clk),
        .cs_n       (cs_n),
        .dq_in      (dq),
        .smask_wire (sm_w),
        .smask_out  (sm_out),
        .smask_oe   (sm_oe)
    );

    task automatic end_sim;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic bad(input string s);
        err_count++;
        $display("unexpected at %0t: %s", $time, s);
    endtask

    task automatic chk(input logic [5:0] a, input logic [15:0] e);
        repeat (10) @(posedge clk_sys);
        #1 pa = a;
        repeat (3) @(posedge clk_sys);
        #1 samples_checked++;
        if (peek_data !== e) bad($sformatf("word %0d is %h", a, peek_data));
    endtask

    task automatic flt(input logic use_lvl, input logic e);
        samples_checked++;
        if (pdw_host_inst.fault !== 1'b0) bad("strobe misbehaved");
        if (use_lvl && pdw_host_inst.ca_lvl !== e) bad("latency flag");
        pdw_host_inst.fault = 1'b0;
    endtask

    // Both frames finish before the first refresh request is due
    task automatic t_zero_then_mask;
        pdw_host_inst.frame(0, 1, 6'h05, 2, 2, {16'hBBBB, 16'hAAAA},
                            {2'b11, 2'b11});
        flt(1, 1'b0);
        pdw_host_inst.frame(0, 0, 6'h05, 2, 2, {16'h4433, 16'h2211},
                            {2'b01, 2'b10});
        flt(1, 1'b0);
        chk(6'h05, 16'hAA11);
        chk(6'h06, 16'h44BB);
    endtask

    task automatic t_extra;
        repeat (REFRESH_CYC) @(posedge clk_sys);
        #1 samples_checked++;
        if (pend !== 1'b1) bad("no refresh request");
        // Link clock stands still between frames; a short read carries
        // the refresh level across before the write that must see it
        pdw_host_inst.frame(1, 0, 6'h07, 2, 0, '0, '0);
        flt(0, 1'b0);
        pdw_host_inst.frame(0, 0, 6'h07, 2, 1, {16'h0000, 16'h5A5A},
                            {2'b00, 2'b00});
        flt(1, 1'b1);
        chk(6'h07, 16'h5A5A);
    endtask

    task automatic t_read;
        pdw_host_inst.frame(1, 0, 6'h07, 2, 0, '0, '0);
        flt(0, 1'b0);
        chk(6'h07, 16'h5A5A);
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad("timeout");
            end_sim();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (10) @(posedge clk_sys);
        t_zero_then_mask();
        t_extra();
        t_read();
        end_sim();
    end
endmodule
`default_nettype wire
